// >>> common/fsca_pkg.sv
// Purpose: Shared constants and types for the flash status and configuration access unit.
// Assumes: SPI mode 0 or 3; the system clock is far faster than the serial clock.
// Notes:   Opcodes, bit positions and default timing counts live here; the bench sets its own program count and the bound assertions take that of fsca_top.
package fsca_pkg;

	// Opcodes and command sequence bytes.
	localparam logic [7:0] OP_STATUS_READ = 8'hd7;
	localparam logic [7:0] OP_CFG_READ    = 8'h3f;
	localparam logic [7:0] SEQ_B1         = 8'h3d;
	localparam logic [7:0] SEQ_B2         = 8'h2a;
	localparam logic [7:0] SEQ_B3         = 8'h81;
	localparam logic [7:0] SEQ_QUAD_ON    = 8'h66;
	localparam logic [7:0] SEQ_QUAD_OFF   = 8'h67;

	// Field positions.
	localparam int IDLE_BIT      = 7;
	localparam int MATCH_BIT     = 6;
	localparam int CAP_LSB       = 2;
	localparam int GUARD_BIT     = 1;
	localparam int PAGE_BIT      = 0;
	localparam int WFAIL_BIT     = 5;
	localparam int LOCKDOWN_BIT  = 3;
	localparam int HOLD_TWO_BIT  = 2;
	localparam int HOLD_ONE_BIT  = 1;
	localparam int ERASE_HB_BIT  = 0;
	localparam int QUAD_BIT      = 7;

	// Shipped power-up value and fixed read-only patterns.
	localparam logic [7:0] CFG_RESERVED_VAL = 8'h08;
	localparam logic       QUAD_SHIP_VAL    = 1'b0;
	localparam logic [3:0] CAP_CODE_DEFAULT = 4'h5;

	// Configuration program time in ns and its cycle count at 200 MHz.
	localparam int CLK_PERIOD_NS        = 5;
	localparam int CFG_PROGRAM_TIME_NS  = 15000000;
	localparam int CFG_PROGRAM_CYCLES   = CFG_PROGRAM_TIME_NS / CLK_PERIOD_NS;
	localparam int BIT_CNT_RESET        = 0;

	typedef enum logic [1:0] {
		FSCA_CMD    = 2'b00,
		FSCA_STATUS = 2'b01,
		FSCA_CFG    = 2'b11,
		FSCA_IGNORE = 2'b10
	} fsca_mode_t;

	// Device-side condition inputs gathered as one carrier.
	typedef struct packed {
		logic       op_running;
		logic       match_fail;
		logic       guard_active;
		logic       binary_page;
		logic       write_fail;
		logic       lockdown_allowed;
		logic       prog_hold_buf_two;
		logic       prog_hold_buf_one;
		logic       erasure_halted;
	} fsca_cond_t;

	// Serial output pin as data plus enable.
	typedef struct packed {
		logic data;
		logic oe;
	} fsca_so_t;

endpackage

// >>> rtl/fsca_top.sv
// Purpose: Status read, configuration read and quad enable/disable for a serial flash.
// Assumes: Pins are asynchronous and pass two flip-flops; serial clock below mclk/4.
// Notes:   The four_lane_enable bit models a nonvolatile cell and keeps its value across
//          rst_n_in; only a power-up of the simulator leaves it at its shipped value.
`timescale 1ns/10ps

// Functional notes
// - Opcode D7h starts status output, one bit per serial clock after the opcode.
// - After status byte two, output restarts at status byte one while selected.
// - Status read accepted anytime, even busy; every repetition uses fresh values.
// - Bit 7 of both bytes is idle_flag, resampled for each byte sent.
// - Deselecting at any time ends the read and floats the serial output.
// - Byte one bit 6 shows the latest compare result, 1 on mismatch.
// - Byte one bits 5:2 return a fixed capacity lookup code.
// - Byte one bit 1 reads 1 while sector protection is enabled.
// - Byte one bit 0 reads 1 for 512-byte pages, 0 for 528.
// - Byte two bit 5 reports a real erase or program failure only.
// - Byte two bit 3 reads 1 while sector lockdown is still accepted.
// - Byte two bit 2 flags a suspended buffer-two program.
// - Byte two bit 1 flags a suspended buffer-one program.
// - Byte two bit 0 flags any suspended erase.
// - Opcode 3Fh, issued when idle, repeats the configuration byte while selected.
// - Above rated clock the first configuration byte is invalid; host uses later.
// - Configuration byte is nonvolatile; reset leaves four_lane_enable alone; ships 0.
// - Only bit 7 is writable via commands; bit 3 reads 1, others 0.
// - With quad enabled, quad commands valid and guard/reset pins become data lanes.
// - With quad disabled, quad opcodes invalid and pins keep control functions.
// - Sequence 3D 2A 81 66 then deselect programs four_lane_enable to 1.
// - Sequence 3D 2A 81 67 then deselect programs four_lane_enable to 0.
// - While programming the configuration byte, status reports busy.
module fsca_top
	import fsca_pkg::*;
#(
	parameter logic [3:0] CAP_CODE       = CAP_CODE_DEFAULT,
	parameter int         CFG_PROG_COUNT = CFG_PROGRAM_CYCLES
)
(
	// Clock and reset
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	// Serial pins from the host
	input  wire logic             cs_n_in,
	input  wire logic             sclk_in,
	input  wire logic             si_in,
	// Serial output pin
	output fsca_pkg::fsca_so_t    so_out,
	// Internal device conditions
	input  fsca_pkg::fsca_cond_t  cond_in,
	// Quad lane control
	output logic                  four_lane_enable_out,
	output logic                  quad_cmds_valid_out,
	output logic                  pins_as_lanes_out,
	output logic                  cfg_busy_out
);
	import fsca_pkg::*;

	logic [2:0]  cs_sync_reg;
	logic [2:0]  sclk_sync_reg;
	logic [1:0]  si_sync_reg;
	logic        cs_act;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_end;
	logic [7:0]  shift_reg;
	logic [7:0]  shift_next;
	logic [2:0]  bit_cnt_reg;
	logic [2:0]  byte_cnt_reg;
	fsca_mode_t  mode_reg;
	logic        seq_ok_reg;
	logic [1:0]  seq_kind_reg;
	logic [7:0]  tx_reg;
	logic        tx_second_reg;
	logic        quad_reg = QUAD_SHIP_VAL;
	logic        quad_target_reg;
	logic        prog_active_reg;
	logic [31:0] prog_cnt_reg;
	logic [7:0]  status_one;
	logic [7:0]  status_two;
	logic [7:0]  cfg_byte;
	logic        busy;

	// The middle and last stages feed logic; the first stage is read by nothing else.
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			cs_sync_reg   <= 3'h7;
			sclk_sync_reg <= 3'h0;
			si_sync_reg   <= 2'h0;
		end
		else
		begin
			cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_in};
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
			si_sync_reg   <= {si_sync_reg[0], si_in};
		end
	end

	assign cs_act    = !cs_sync_reg[1];
	assign cs_end    = cs_sync_reg[1] && !cs_sync_reg[2];
	assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
	assign sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];
	assign shift_next = {shift_reg[6:0], si_sync_reg[1]};

	assign busy = cond_in.op_running || prog_active_reg;

	// Status bytes are built combinationally so every byte load sees fresh values.
	always_comb
	begin
		status_one               = 8'h00;
		status_one[IDLE_BIT]     = !busy;
		status_one[MATCH_BIT]    = cond_in.match_fail;
		status_one[CAP_LSB +: 4] = CAP_CODE;
		status_one[GUARD_BIT]    = cond_in.guard_active;
		status_one[PAGE_BIT]     = cond_in.binary_page;
		status_two               = 8'h00;
		status_two[IDLE_BIT]     = !busy;
		status_two[WFAIL_BIT]    = cond_in.write_fail;
		status_two[LOCKDOWN_BIT] = cond_in.lockdown_allowed;
		status_two[HOLD_TWO_BIT] = cond_in.prog_hold_buf_two;
		status_two[HOLD_ONE_BIT] = cond_in.prog_hold_buf_one;
		status_two[ERASE_HB_BIT] = cond_in.erasure_halted;
		cfg_byte                 = CFG_RESERVED_VAL;
		cfg_byte[QUAD_BIT]       = quad_reg;
	end

	// Input shifter and bit counter, restarted by each new frame.
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in || !cs_act)
		begin
			shift_reg    <= 8'h00;
			bit_cnt_reg  <= 3'(BIT_CNT_RESET);
			byte_cnt_reg <= 3'h0;
		end
		else if (sclk_rise)
		begin
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == 3'h7 && byte_cnt_reg != 3'h7)
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
		end
	end

	// Command decoding: the first byte picks the mode, later bytes check the sequence.
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in || !cs_act)
		begin
			mode_reg     <= FSCA_CMD;
			seq_ok_reg   <= 1'b0;
			seq_kind_reg <= 2'h0;
		end
		else if (sclk_rise && bit_cnt_reg == 3'h7)
		begin
			unique case (mode_reg)
				FSCA_CMD:
				begin
					if (shift_next == OP_STATUS_READ)
						mode_reg <= FSCA_STATUS;
					else if (shift_next == OP_CFG_READ && !busy)
						mode_reg <= FSCA_CFG;
					else if (shift_next == SEQ_B1 && !busy)
					begin
						mode_reg   <= FSCA_IGNORE;
						seq_ok_reg <= 1'b1;
					end
					else
						mode_reg <= FSCA_IGNORE;
				end
				FSCA_IGNORE:
				begin
					if (byte_cnt_reg == 3'h1)
						seq_ok_reg <= seq_ok_reg && shift_next == SEQ_B2;
					else if (byte_cnt_reg == 3'h2)
						seq_ok_reg <= seq_ok_reg && shift_next == SEQ_B3;
					else if (byte_cnt_reg == 3'h3)
					begin
						if (seq_ok_reg && shift_next == SEQ_QUAD_ON)
							seq_kind_reg <= 2'h1;
						else if (seq_ok_reg && shift_next == SEQ_QUAD_OFF)
							seq_kind_reg <= 2'h2;
						else
							seq_kind_reg <= 2'h0;
					end
					else
						seq_kind_reg <= 2'h0; // Extra bytes void the command.
				end
				FSCA_STATUS, FSCA_CFG:
				begin
					mode_reg <= mode_reg;
				end
			endcase
		end
	end

	// Output shifter: a byte is loaded at the opcode's last rising edge and each
	// eighth rising edge after, and bits change on falling edges of the serial clock.
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in || !cs_act)
		begin
			tx_reg        <= 8'h00;
			tx_second_reg <= 1'b0;
		end
		else if (sclk_rise && bit_cnt_reg == 3'h7)
		begin
			if (mode_reg == FSCA_CMD && shift_next == OP_STATUS_READ)
			begin
				tx_reg        <= status_one;
				tx_second_reg <= 1'b1;
			end
			else if (mode_reg == FSCA_CMD)
				tx_reg <= cfg_byte;
			else if (mode_reg == FSCA_STATUS)
			begin
				tx_reg        <= tx_second_reg ? status_two : status_one;
				tx_second_reg <= !tx_second_reg;
			end
			else
				tx_reg <= cfg_byte;
		end
		else if (sclk_fall && bit_cnt_reg != 3'h0)
			tx_reg <= {tx_reg[6:0], 1'b0};
	end

	// Serial output pin, floated whenever the frame is not a read.
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in || !cs_act)
			so_out <= '0;
		else if (sclk_fall && (mode_reg == FSCA_STATUS || mode_reg == FSCA_CFG))
		begin
			so_out.oe <= 1'b1;
			// The shifter moves on this same edge, so a shifting fall must show the next bit.
			if (bit_cnt_reg == 3'h0)
				so_out.data <= tx_reg[7];
			else
				so_out.data <= tx_reg[6];
		end
	end

	// Program cycle for the configuration bit, started only by a complete sequence.
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			prog_active_reg <= 1'b0;
			prog_cnt_reg    <= 32'h0;
			quad_target_reg <= 1'b0;
		end
		else if (cs_end && seq_kind_reg != 2'h0 && !prog_active_reg)
		begin
			prog_active_reg <= 1'b1;
			prog_cnt_reg    <= 32'(CFG_PROG_COUNT);
			quad_target_reg <= seq_kind_reg == 2'h1;
		end
		else if (prog_active_reg)
		begin
			if (prog_cnt_reg <= 32'h1)
				prog_active_reg <= 1'b0;
			prog_cnt_reg <= prog_cnt_reg - 32'h1;
		end
	end

	// Nonvolatile cell: not touched by reset, only by a finishing program cycle.
	always_ff @(posedge mclk_in)
	begin
		if (prog_active_reg && prog_cnt_reg <= 32'h1)
			quad_reg <= quad_target_reg;
	end

	// Quad-lane effects of the configuration bit.
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			four_lane_enable_out <= 1'b0;
			quad_cmds_valid_out  <= 1'b0;
			pins_as_lanes_out    <= 1'b0;
			cfg_busy_out         <= 1'b0;
		end
		else
		begin
			four_lane_enable_out <= quad_reg;
			quad_cmds_valid_out  <= quad_reg;
			pins_as_lanes_out    <= quad_reg;
			cfg_busy_out         <= prog_active_reg;
		end
	end

endmodule

// >>> verif/flash_status_config_access_bench.sv
// Purpose: Self-checking bench for status read, configuration read and quad commands.
// Assumes: Shortened program count; random device conditions from a fixed seed.
// Notes:   Expected bytes come from the condition seen when each byte is loaded.
`timescale 1ns/10ps
module flash_status_config_access_bench;
	import fsca_pkg::*;
	localparam int PROG = 400;
	// Capacity code value is arbitrary.
	localparam logic [3:0] CAP = 4'ha;
	logic       mclk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       cs_n;
	logic       sclk;
	logic       si;
	logic       qe;
	logic       qv;
	logic       pl;
	logic       busy;
	fsca_cond_t cond_in = '0;
	fsca_so_t   so_out;
	logic [7:0] rx;
	logic [31:0] seed = 32'h21;
	int         fails = 0;
	int         checks = 0;

	always #2.5 mclk_in = ~mclk_in;

	fsca_host fsca_host_inst (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so_out));
	fsca_top #(.CAP_CODE(CAP), .CFG_PROG_COUNT(PROG)) fsca_top_inst (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si), .so_out(so_out),
		.cond_in(cond_in), .four_lane_enable_out(qe), .quad_cmds_valid_out(qv),
		.pins_as_lanes_out(pl), .cfg_busy_out(busy));

	task automatic report_and_stop();
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic [7:0] stat(input fsca_cond_t c, input int idx, input logic pb);
		logic idle;
		idle = ~(c.op_running | pb);
		if (idx == 0)
			return {idle, c.match_fail, CAP, c.guard_active, c.binary_page};
		return {idle, 1'b0, c.write_fail, 1'b0, c.lockdown_allowed, c.prog_hold_buf_two,
			c.prog_hold_buf_one, c.erasure_halted};
	endfunction
	// Conditions change after every byte, so each repetition must show fresh values.
	task automatic status_read(input int nbytes, input logic pb);
		fsca_cond_t p;
		p = cond_in;
		fsca_host_inst.sel();
		fsca_host_inst.shift(OP_STATUS_READ, 8, rx);
		for (int j = 0; j < nbytes; j++)
		begin
			@(negedge mclk_in);
			seed = xorshift(seed);
			cond_in = fsca_cond_t'(seed[8:0]);
			fsca_host_inst.shift(8'h00, 8, rx);
			chk(rx, stat(p, j % 2, pb));
			p = cond_in;
		end
		fsca_host_inst.shift(8'h00, 3, rx);
		fsca_host_inst.desel();
		@(negedge mclk_in);
		cond_in = '0;
	endtask
	task automatic cfg_read(input logic q);
		fsca_host_inst.sel();
		fsca_host_inst.shift(OP_CFG_READ, 8, rx);
		for (int j = 0; j < 2; j++)
		begin
			fsca_host_inst.shift(8'h00, 8, rx);
			chk(rx, {q, 7'h08});
		end
		fsca_host_inst.desel();
	endtask
	task automatic quad_cmd(input logic [7:0] last, input int n);
		logic [7:0] seq [4];
		seq = '{SEQ_B1, SEQ_B2, SEQ_B3, last};
		fsca_host_inst.sel();
		for (int i = 0; i < n; i++)
			fsca_host_inst.shift(seq[i], 8, rx);
		fsca_host_inst.desel();
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 4 * PROG)
		begin
			@(negedge mclk_in);
			k++;
		end
		if (k >= 4 * PROG)
		begin
			fails++;
			report_and_stop();
		end
		@(negedge mclk_in);
	endtask

	initial
	begin
		repeat (2) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		for (int r = 0; r < 3; r++)
			status_read(4, 1'b0);
		cfg_read(QUAD_SHIP_VAL);
		quad_cmd(SEQ_QUAD_ON, 3);
		chk({7'h00, busy}, 8'h00);
		quad_cmd(SEQ_QUAD_ON, 4);
		chk({7'h00, busy}, 8'h01);
		status_read(1, 1'b1);
		wait_idle();
		chk({5'h00, qe, qv, pl}, 8'h07);
		rst_n_in = 1'b0;
		repeat (2) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		chk({5'h00, qe, qv, pl}, 8'h07);
		cfg_read(1'b1);
		quad_cmd(SEQ_QUAD_OFF, 4);
		wait_idle();
		chk({5'h00, qe, qv, pl}, 8'h00);
		cfg_read(1'b0);
		report_and_stop();
	end
endmodule

// >>> verif/fsca_host.sv
// Purpose: Serial host model driving select, clock and data toward the device.
// Assumes: Mode 0, MSB first, 48 ns serial clock period.
// Notes:   The clock stands low between frames.
`timescale 1ns/10ps
module fsca_host
	import fsca_pkg::*;
(
	// Pins toward the device
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      si_out,
	// Serial output of the device
	input  fsca_so_t  so_in
);
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b1;
	end
	task automatic sel();
		cs_n_out = 1'b0;
		#48;
	endtask
	// Released data shows the inverse of its last bit so a stale bit never reads right.
	task automatic desel();
		#24;
		cs_n_out = 1'b1;
		si_out = ~si_out;
		#200;
	endtask
	task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nbits; i--)
		begin
			si_out = tx[i];
			#24;
			rx[i] = so_in.data;
			sclk_out = 1'b1;
			#24;
			sclk_out = 1'b0;
		end
	endtask
endmodule

// >>> verif/fsca_top_assertions.sv
// Purpose: Port-level checks for the flash status and configuration access unit.
// Assumes: Single clock domain; rst_n_in synchronous, active low.
// Notes:   Bound into fsca_top; sees only its ports.
`timescale 1ns/10ps
module fsca_top_assertions
	import fsca_pkg::*;
#(
	parameter int CFG_PROG_COUNT = 20
)
(
	// Clock and reset
	input wire logic             mclk_in,
	input wire logic             rst_n_in,
	// Serial pins
	input wire logic             cs_n_in,
	input wire logic             sclk_in,
	input fsca_pkg::fsca_so_t    so_out,
	// Quad lane control
	input logic                  four_lane_enable_out,
	input logic                  quad_cmds_valid_out,
	input logic                  pins_as_lanes_out,
	input logic                  cfg_busy_out
);
	int unsigned busy_cnt_reg;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Length of the current program cycle, cleared whenever it is not busy.
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in || !cfg_busy_out)
			busy_cnt_reg <= 0;
		else
			busy_cnt_reg <= busy_cnt_reg + 1;
	end

	a_float_deselect: assert property (cs_n_in [*6] |-> !so_out.oe)
		else $error("serial output driven while deselected");
	a_drive_on_fall: assert property ($rose(so_out.oe) |-> !cs_n_in && !sclk_in)
		else $error("output enabled outside a selected low clock phase");
	a_bit_on_fall: assert property (so_out.oe && $past(so_out.oe) && $changed(so_out.data)
		|-> !sclk_in)
		else $error("output bit changed while serial clock high");
	a_lanes_follow: assert property ($past(rst_n_in) |-> quad_cmds_valid_out ==
		four_lane_enable_out && pins_as_lanes_out == four_lane_enable_out)
		else $error("lane controls differ from quad enable");
	a_qe_only_prog: assert property ($past(rst_n_in, 2) && $changed(four_lane_enable_out)
		|-> $past(cfg_busy_out) || $past(cfg_busy_out, 2))
		else $error("quad enable changed without a program cycle");
	a_busy_length: assert property ($fell(cfg_busy_out) |-> busy_cnt_reg == CFG_PROG_COUNT)
		else $error("program cycle length wrong");
	a_busy_after_desel: assert property ($rose(cfg_busy_out) |-> cs_n_in && !so_out.oe)
		else $error("program cycle started while selected");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |=> !so_out.oe &&
		!cfg_busy_out && !four_lane_enable_out)
		else $error("outputs active during reset");
endmodule

bind fsca_top fsca_top_assertions #(.CFG_PROG_COUNT(CFG_PROG_COUNT)) fsca_top_assertions_inst (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
	.so_out(so_out), .four_lane_enable_out(four_lane_enable_out),
	.quad_cmds_valid_out(quad_cmds_valid_out), .pins_as_lanes_out(pins_as_lanes_out),
	.cfg_busy_out(cfg_busy_out));
